// ===== hdl/cio_pkg.sv
package cio_pkg;
    // Register byte offsets
    localparam logic [7:0] CIO_OFF_CTRL = 8'h00;
    localparam logic [7:0] CIO_OFF_STATUS = 8'h04;
    localparam logic [7:0] CIO_OFF_RELAY = 8'h08;
    localparam logic [7:0] CIO_OFF_MON = 8'h0c;
    localparam logic [7:0] CIO_OFF_LINK = 8'h10;
    localparam logic [1:0] CIO_RESP_OKAY = 2'h0;
    localparam logic [1:0] CIO_RESP_SLVERR = 2'h2;

    // Contact inputs
    localparam int CIO_IN_RUN = 0;
    localparam int CIO_IN_PAUSE = 1;
    localparam int CIO_IN_WAIT = 2;
    localparam int CIO_IN_SAFE = 3;
    localparam int CIO_NUM_IN = 4;
    localparam int CIO_NUM_RELAY = 4;

    // Program files
    localparam logic [4:0] CIO_SAFETY_FILE = 5'h18;

    // Link identity
    localparam logic [5:0] CIO_ID_DEFAULT = 6'h01;
    localparam logic [3:0] CIO_ROT_ID_MAX = 4'h9;

    // Bit-rate codes
    localparam logic [2:0] CIO_RATE_EXT = 3'h0;
    localparam logic [2:0] CIO_RATE_1200 = 3'h1;
    localparam logic [2:0] CIO_RATE_2400 = 3'h2;
    localparam logic [2:0] CIO_RATE_4800 = 3'h3;
    localparam logic [2:0] CIO_RATE_9600 = 3'h4;
    localparam logic [2:0] CIO_RATE_19200 = 3'h5;
    // Rear rate selector
    localparam logic [1:0] CIO_ROT_EXT = 2'h0;
    localparam logic [1:0] CIO_ROT_9600 = 2'h1;
    localparam logic [1:0] CIO_ROT_19200 = 2'h2;

    // Timing
    localparam int CIO_CLK_HZ = 20_000_000;
    localparam int CIO_BAUD_BASE = 1200;
    localparam int CIO_DIV_BASE = CIO_CLK_HZ / CIO_BAUD_BASE;
    localparam int CIO_DEBOUNCE_MS = 5;
    localparam int CIO_DEBOUNCE_CYC = CIO_CLK_HZ / 1000 * CIO_DEBOUNCE_MS;
    localparam int CIO_MS_CYC = CIO_CLK_HZ / 1000;

    // Monitor selections
    localparam logic [2:0] CIO_MON_PRESS = 3'h0;
    localparam logic [2:0] CIO_MON_FLOW = 3'h1;
    localparam logic [2:0] CIO_MON_PCT_A = 3'h2;

    // Relay operations
    typedef enum logic [1:0] {
        CIO_RLY_NONE = 2'h0,
        CIO_RLY_OPEN = 2'h1,
        CIO_RLY_CLOSE = 2'h2,
        CIO_RLY_PULSE = 2'h3
    } cio_rly_op_t;

    typedef struct packed {
        logic [15:0] ms;
        logic [11:0] rsvd;
        cio_rly_op_t op;
        logic [1:0] idx;
    } cio_relay_cmd_t;

    typedef struct packed {
        logic [18:0] rsvd1;
        logic [4:0] prog_file;
        logic [3:0] rsvd0;
        logic aux_auto;
        logic aux_manual;
        logic panel_model;
        logic pause_flow;
    } cio_ctrl_t;

    typedef struct packed {
        logic [20:0] rsvd1;
        logic [2:0] rate;
        logic [1:0] rsvd0;
        logic [5:0] id;
    } cio_link_t;

    localparam cio_ctrl_t CIO_CTRL_RST = '{prog_file: 5'h00,
        panel_model: 1'b1, default: '0};
    localparam cio_link_t CIO_LINK_RST = '{id: CIO_ID_DEFAULT,
        rate: CIO_RATE_EXT, default: '0};
endpackage : cio_pkg

// ===== hdl/cio_debounce.sv
`timescale 1ns/1ps
// Synchroniser, filter and edge pulses for one contact
module cio_debounce
    import cio_pkg::*;
#(
    parameter int DEB_CYC = CIO_DEBOUNCE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_q, s2_q;
    logic [23:0] cnt_q;

    // Synchroniser; first flop feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
        end
    end

    // Level follows only after a full stable window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else if (ce) begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (s2_q == level) begin
                cnt_q <= '0;
            end else if (cnt_q >= 24'(DEB_CYC - 1)) begin
                cnt_q <= '0;
                level <= s2_q;
                rise <= s2_q;
                fall <= !s2_q;
            end else begin
                cnt_q <= cnt_q + 24'h000001;
            end
        end
    end
endmodule : cio_debounce

// ===== hdl/cio_baud_gen.sv
`timescale 1ns/1ps
// Internal bit-rate tick every div cycles
module cio_baud_gen (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic en,
    input wire logic [15:0] div,
    output logic tick
);
    logic [15:0] cnt_q;

    // Restart on disable so a new rate starts clean
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (!en) begin
                cnt_q <= '0;
            end else if (cnt_q >= div - 16'h0001) begin
                cnt_q <= '0;
                tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule : cio_baud_gen

// ===== hdl/cio_contact_io.sv
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// RL1 - Run contact close starts, open stops
// RL2 - Pause contact closures alternate pause and resume
// RL3 - Pause with flow holds setpoints, resumes same step
// RL4 - Inputs except wait act on edges only
// RL5 - Wait contact level lets program pass wait
// RL6 - Safety contact closure launches program file 24
// RL7 - Four relays: open, close, or timed pulse
// RL8 - Aux 12 V by manual or program step
// RL9 - Monitor follows pressure, flow or one solvent
// RL10 - Panel model takes identity 0 to 63
// RL11 - Panel-less model takes identity from rotary
// RL12 - Master default identity is 1
// RL13 - Integrator keeps identities unique per level
// RL14 - Rate selector: 0 link, 1 9600, 2 19200
// RL15 - Slave pumps must select the link clock
// RL16 - Panel model rates 1200 to 19200 or link
// RL17 - Internal rate only without link clock
// RL18 - Contacts synchronised and debounced before edges
module cio_contact_io
    import cio_pkg::*;
#(
    parameter int DEB_CYC = CIO_DEBOUNCE_CYC,
    parameter int MS_CYC = CIO_MS_CYC,
    parameter int DIV_BASE = CIO_DIV_BASE
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CE,
    // AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Contacts, rotary selectors and link clock pins
    input wire logic [3:0] CONTACT_IN,
    input wire logic [3:0] ROT_ID,
    input wire logic [1:0] ROT_RATE,
    input wire logic LINK_CLK,
    // Same-clock inputs from the pump logic
    input wire logic AUX_STEP_ON,
    input wire logic [11:0] PRESSURE_VAL,
    input wire logic [11:0] FLOW_VAL,
    input wire logic [31:0] PCT_VAL,
    // Outputs
    output logic [3:0] RELAY_OUT,
    output logic AUX_12V_EN,
    output logic [11:0] MON_OUT,
    output logic PROG_RUN,
    output logic PROG_PAUSED,
    output logic FLOW_EN,
    output logic SETPOINT_HOLD,
    output logic STEP_EN,
    output logic WAIT_READY,
    output logic PROG_LOAD,
    output logic [4:0] PROG_FILE,
    output logic [5:0] LINK_ID,
    output logic LINK_EXT_CLK,
    output logic BIT_TICK
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PAUSE} cio_state_t;

    cio_state_t state_q;
    cio_ctrl_t ctrl_q;
    cio_link_t link_q;
    logic [2:0] mon_sel_q;
    logic safety_q;
    logic [3:0] lvl, rise, fall;
    logic [3:0] rid_s1_q, rid_s2_q;
    logic [1:0] rrt_s1_q, rrt_s2_q;
    logic lk_s1_q, lk_s2_q, lk_s3_q;
    logic int_tick;
    logic [15:0] div_d;
    logic ext_d;
    logic [15:0] ms_cnt_q;
    logic ms_tick;
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [31:0] wmask;
    logic wr_go;
    logic rly_go;
    cio_relay_cmd_t rly_cmd;
    logic [31:0] rd_d;
    logic rd_ok;

    // Contact filters [RL18]
    generate
        for (genvar i = 0; i < CIO_NUM_IN; i++) begin : g_in
            cio_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
                .clk(CORE_CLK),
                .rst_n(RST_N),
                .ce(CE),
                .pin(CONTACT_IN[i]),
                .level(lvl[i]),
                .rise(rise[i]),
                .fall(fall[i])
            );
        end
    endgenerate

    // Rotary selectors and link clock are asynchronous
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rid_s1_q <= '0;
            rid_s2_q <= '0;
            rrt_s1_q <= '0;
            rrt_s2_q <= '0;
            lk_s1_q <= 1'b0;
            lk_s2_q <= 1'b0;
            lk_s3_q <= 1'b0;
        end else if (CE) begin
            rid_s1_q <= ROT_ID;
            rid_s2_q <= rid_s1_q;
            rrt_s1_q <= ROT_RATE;
            rrt_s2_q <= rrt_s1_q;
            lk_s1_q <= LINK_CLK;
            lk_s2_q <= lk_s1_q;
            lk_s3_q <= lk_s2_q;
        end
    end

    // Program state machine
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            safety_q <= 1'b0;
            PROG_LOAD <= 1'b0;
            PROG_FILE <= '0;
        end else if (CE) begin
            PROG_LOAD <= 1'b0;
            if (rise[CIO_IN_SAFE]) begin
                state_q <= ST_RUN; // [RL6]
                safety_q <= 1'b1;
                PROG_LOAD <= 1'b1;
                PROG_FILE <= CIO_SAFETY_FILE; // [RL6]
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (rise[CIO_IN_RUN]) begin
                            state_q <= ST_RUN; // [RL1] [RL4]
                            safety_q <= 1'b0;
                            PROG_LOAD <= 1'b1;
                            PROG_FILE <= ctrl_q.prog_file;
                        end
                    end
                    ST_RUN: begin
                        if (fall[CIO_IN_RUN]) begin
                            state_q <= ST_IDLE; // [RL1] [RL4]
                        end else if (rise[CIO_IN_PAUSE]) begin
                            state_q <= ST_PAUSE; // [RL2] [RL4]
                        end
                    end
                    ST_PAUSE: begin
                        if (fall[CIO_IN_RUN]) begin
                            state_q <= ST_IDLE; // [RL1]
                        end else if (rise[CIO_IN_PAUSE]) begin
                            state_q <= ST_RUN; // [RL2] [RL3]
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Program levels; a pause freezes the step
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PROG_RUN <= 1'b0;
            PROG_PAUSED <= 1'b0;
            FLOW_EN <= 1'b0;
            SETPOINT_HOLD <= 1'b0;
            STEP_EN <= 1'b0;
            WAIT_READY <= 1'b0;
        end else if (CE) begin
            PROG_RUN <= state_q != ST_IDLE;
            PROG_PAUSED <= state_q == ST_PAUSE;
            FLOW_EN <= (state_q == ST_RUN) ||
                ((state_q == ST_PAUSE) && ctrl_q.pause_flow); // [RL2] [RL3]
            SETPOINT_HOLD <= (state_q == ST_PAUSE) &&
                ctrl_q.pause_flow; // [RL3]
            STEP_EN <= (state_q == ST_RUN); // [RL3]
            WAIT_READY <= lvl[CIO_IN_WAIT]; // Level, not edge [RL5]
        end
    end

    // Millisecond base for relay pulses
    assign ms_tick = (ms_cnt_q >= 16'(MS_CYC - 1));
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ms_cnt_q <= '0;
        end else if (CE) begin
            ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 16'h0001;
        end
    end

    // Relays: a new command replaces a running pulse
    assign rly_cmd = cio_relay_cmd_t'(w_data_q);
    assign rly_go = wr_go && (aw_addr_q == CIO_OFF_RELAY);
    generate
        for (genvar r = 0; r < CIO_NUM_RELAY; r++) begin : g_rly
            logic [15:0] left_q;
            always_ff @(posedge CORE_CLK or negedge RST_N) begin
                if (!RST_N) begin
                    left_q <= '0;
                    RELAY_OUT[r] <= 1'b0;
                end else if (CE) begin
                    if (rly_go && (rly_cmd.idx == 2'(r))) begin
                        case (rly_cmd.op)
                            CIO_RLY_OPEN: begin
                                RELAY_OUT[r] <= 1'b0; // [RL7]
                                left_q <= '0;
                            end
                            CIO_RLY_CLOSE: begin
                                RELAY_OUT[r] <= 1'b1; // [RL7]
                                left_q <= '0;
                            end
                            CIO_RLY_PULSE: begin
                                RELAY_OUT[r] <= rly_cmd.ms != '0; // [RL7]
                                left_q <= rly_cmd.ms;
                            end
                            default: left_q <= left_q;
                        endcase
                    end else if (ms_tick && left_q != '0) begin
                        left_q <= left_q - 16'h0001;
                        if (left_q == 16'h0001) begin
                            RELAY_OUT[r] <= 1'b0; // End of pulse [RL7]
                        end
                    end
                end
            end
        end
    endgenerate

    // Aux supply and monitor
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            AUX_12V_EN <= 1'b0;
            MON_OUT <= '0;
        end else if (CE) begin
            AUX_12V_EN <= ctrl_q.aux_auto ? AUX_STEP_ON :
                ctrl_q.aux_manual; // [RL8]
            case (mon_sel_q)
                CIO_MON_PRESS: MON_OUT <= PRESSURE_VAL; // [RL9]
                CIO_MON_FLOW: MON_OUT <= FLOW_VAL; // [RL9]
                default: begin
                    // Percent byte fills the upper bits
                    MON_OUT <= {PCT_VAL[8 * (mon_sel_q - CIO_MON_PCT_A) +: 8],
                        4'h0}; // [RL9]
                end
            endcase
        end
    end

    // Bit clock source per model
    always_comb begin
        ext_d = 1'b0;
        div_d = 16'(DIV_BASE);
        if (ctrl_q.panel_model) begin
            case (link_q.rate) // [RL16]
                CIO_RATE_1200: div_d = 16'(DIV_BASE);
                CIO_RATE_2400: div_d = 16'(DIV_BASE / 2);
                CIO_RATE_4800: div_d = 16'(DIV_BASE / 4);
                CIO_RATE_9600: div_d = 16'(DIV_BASE / 8);
                CIO_RATE_19200: div_d = 16'(DIV_BASE / 16);
                default: ext_d = 1'b1; // [RL15] [RL17]
            endcase
        end else begin
            case (rrt_s2_q) // [RL14]
                CIO_ROT_9600: div_d = 16'(DIV_BASE / 8);
                CIO_ROT_19200: div_d = 16'(DIV_BASE / 16);
                default: ext_d = 1'b1; // [RL14]
            endcase
        end
    end

    cio_baud_gen u_baud (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .en(!ext_d), // [RL17]
        .div(div_d),
        .tick(int_tick)
    );

    // Bit tick from link clock edge or divider
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            LINK_ID <= CIO_ID_DEFAULT;
            LINK_EXT_CLK <= 1'b1;
            BIT_TICK <= 1'b0;
        end else if (CE) begin
            if (ctrl_q.panel_model) begin
                LINK_ID <= link_q.id; // [RL10]
            end else begin
                LINK_ID <= {2'b00, (rid_s2_q > CIO_ROT_ID_MAX) ?
                    CIO_ROT_ID_MAX : rid_s2_q}; // [RL11]
            end
            LINK_EXT_CLK <= ext_d;
            BIT_TICK <= ext_d ? (lk_s2_q && !lk_s3_q) : int_tick;
        end
    end

    // Write channel: AW and W in either order
    assign wr_go = aw_hold_q && w_hold_q && !S_AXI_BVALID;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= CIO_RESP_OKAY;
        end else if (CE) begin
            S_AXI_AWREADY <= !aw_hold_q && !S_AXI_AWREADY;
            S_AXI_WREADY <= !w_hold_q && !S_AXI_WREADY;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (aw_addr_q == CIO_OFF_CTRL ||
                    aw_addr_q == CIO_OFF_RELAY ||
                    aw_addr_q == CIO_OFF_MON ||
                    aw_addr_q == CIO_OFF_LINK) ?
                    CIO_RESP_OKAY : CIO_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Register stores honour byte strobes
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
        {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= CIO_CTRL_RST;
            link_q <= CIO_LINK_RST; // Master default identity [RL12]
            mon_sel_q <= CIO_MON_PRESS;
        end else if (CE && wr_go) begin
            case (aw_addr_q)
                CIO_OFF_CTRL: ctrl_q <= cio_ctrl_t'((ctrl_q & ~wmask) |
                    (w_data_q & wmask));
                CIO_OFF_MON: mon_sel_q <= (wmask[0] &&
                    w_data_q[2:0] <= CIO_MON_PCT_A + 3'h3) ?
                    w_data_q[2:0] : mon_sel_q;
                CIO_OFF_LINK: link_q <= cio_link_t'((link_q & ~wmask) |
                    (w_data_q & wmask));
                default: mon_sel_q <= mon_sel_q;
            endcase
        end
    end

    // Read data mux
    always_comb begin
        rd_ok = 1'b1;
        rd_d = '0;
        case (S_AXI_ARADDR)
            CIO_OFF_CTRL: rd_d = ctrl_q;
            CIO_OFF_STATUS: rd_d = {20'h00000, RELAY_OUT, lvl,
                safety_q, WAIT_READY, state_q};
            CIO_OFF_RELAY: rd_d = {28'h0000000, RELAY_OUT};
            CIO_OFF_MON: rd_d = {29'h00000000, mon_sel_q};
            CIO_OFF_LINK: rd_d = {7'h00, LINK_EXT_CLK, 2'h0, LINK_ID,
                link_q[15:0]};
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel: one read at a time
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= CIO_RESP_OKAY;
        end else if (CE) begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY &&
                S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_d;
                S_AXI_RRESP <= rd_ok ? CIO_RESP_OKAY : CIO_RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule : cio_contact_io

// ===== dv/cio_partner.sv
`timescale 1ns/1ps
// Far side: bouncing contacts, framed link clock
module cio_partner (
    input wire logic clk,
    output logic [3:0] contact,
    output logic link_clk
);
    initial begin
        contact = 4'h0;
        link_clk = 1'b0;
    end
    // Two short bounces, then the new state
    task automatic set_contact(input int i, input logic v);
        repeat (2) begin
            @(posedge clk) contact[i] <= v;
            @(posedge clk) contact[i] <= ~v;
        end
        @(posedge clk) contact[i] <= v;
    endtask : set_contact
    // Clock idles low; edges kept off the core clock edge
    task automatic frame(input int n);
        #10;
        repeat (n) begin
            #200 link_clk = 1'b1;
            #200 link_clk = 1'b0;
        end
    endtask : frame
endmodule : cio_partner

// ===== dv/cio_contact_io_chk.sv
`timescale 1ns/1ps
// Port-level checks
module cio_contact_io_chk (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic LINK_CLK,
    input wire logic LINK_EXT_CLK,
    input wire logic BIT_TICK,
    input wire logic PROG_LOAD,
    input wire logic PROG_RUN,
    input wire logic PROG_PAUSED,
    input wire logic FLOW_EN,
    input wire logic SETPOINT_HOLD,
    input wire logic STEP_EN
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    // Answers drop once taken
    AST_B_ONCE: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
        !S_AXI_BVALID) else $error("B repeated");
    AST_R_ONCE: assert property (S_AXI_RVALID && S_AXI_RREADY |=>
        !S_AXI_RVALID) else $error("R repeated");
    AST_LOAD_RUN: assert property (PROG_LOAD |-> ##[0:1] PROG_RUN)
        else $error("load without run");
    AST_LOAD_PULSE: assert property (PROG_LOAD |=> !PROG_LOAD)
        else $error("load too long");
    AST_PAUSE_STILL: assert property (PROG_PAUSED |-> !STEP_EN)
        else $error("step while paused");
    AST_FLOW_HOLD: assert property (PROG_PAUSED && FLOW_EN |->
        SETPOINT_HOLD) else $error("flow pause unheld");
    // Sync delay bounds the tick
    AST_EXT_TICK: assert property (LINK_EXT_CLK && $rose(LINK_CLK)
        |-> ##[1:6] BIT_TICK) else $error("no link tick");
    AST_TICK_PULSE: assert property (BIT_TICK |=> !BIT_TICK)
        else $error("tick too long");
endmodule : cio_contact_io_chk

bind cio_contact_io cio_contact_io_chk cio_contact_io_chk_inst (.*);

// ===== dv/cio_contact_io_tb_top.sv
`timescale 1ns/1ps
module cio_contact_io_tb_top
    import cio_pkg::*;
;
    // Port-named nets for the .* instance
    logic CORE_CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, AUX_STEP_ON = 1'b0;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0, PCT_VAL = 32'h44332211, rq;
    logic [3:0] S_AXI_WSTRB = 4'hf, ROT_ID = 4'h0, RELAY_OUT, CONTACT_IN;
    logic [11:0] PRESSURE_VAL = 12'h123, FLOW_VAL = 12'h456, MON_OUT;
    logic [1:0] ROT_RATE = 2'h0, S_AXI_BRESP, S_AXI_RRESP, rr;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, AUX_12V_EN, PROG_RUN, PROG_PAUSED, FLOW_EN;
    logic SETPOINT_HOLD, STEP_EN, WAIT_READY, PROG_LOAD, LINK_EXT_CLK;
    logic BIT_TICK, LINK_CLK;
    logic [31:0] S_AXI_RDATA;
    logic [4:0] PROG_FILE;
    logic [5:0] LINK_ID;
    int miscompares = 0, n_checks = 0, cyc = 0, loads = 0, ticks = 0, t0;
    typedef struct packed {
        logic [31:0] ctrl, link;
        logic [3:0] rid;
        logic [1:0] rrate;
        logic [5:0] eid;
        logic eext;
    } cio_row_t;
    // Panel versus rear selectors
    localparam cio_row_t ROWS [6] = '{
        '{32'h2, 32'h3f, 4'h0, 2'h0, 6'h3f, 1'b1},
        '{32'h2, 32'h500, 4'h0, 2'h0, 6'h00, 1'b0},
        '{32'h0, 32'h0, 4'h7, 2'h0, 6'h07, 1'b1},
        '{32'h0, 32'h0, 4'hc, 2'h1, 6'h09, 1'b0},
        '{32'h0, 32'h0, 4'h3, 2'h2, 6'h03, 1'b0},
        '{32'h0, 32'h0, 4'h5, 2'h3, 6'h05, 1'b1}};
    cio_contact_io #(.DEB_CYC(4), .MS_CYC(10), .DIV_BASE(64))
        cio_contact_io_inst (.*);
    cio_partner cio_partner_inst (.clk(CORE_CLK), .contact(CONTACT_IN),
        .link_clk(LINK_CLK));
    initial forever #25 CORE_CLK = ~CORE_CLK;
    // Counters and hang limit
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (PROG_LOAD === 1'b1) loads <= loads + 1;
        if (BIT_TICK === 1'b1) ticks <= ticks + 1;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input string s, input logic [33:0] e, g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", s, e, g);
            miscompares++;
        end
    endtask : chk
    // Write (w=1) or read
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} <= {a, a, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {3{w}};
        {S_AXI_ARVALID, S_AXI_RREADY} <= {2{!w}};
        do begin
            @(posedge CORE_CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while ((w ? S_AXI_BVALID : S_AXI_RVALID) !== 1'b1);
        {rq, rr} = {S_AXI_RDATA, w ? S_AXI_BRESP : S_AXI_RRESP};
        {S_AXI_BREADY, S_AXI_RREADY} <= 2'b00;
    endtask : bus
    // Contact change plus filter delay
    task automatic contact(input int i, input logic v);
        cio_partner_inst.set_contact(i, v);
        repeat (20) @(posedge CORE_CLK);
    endtask : contact
    task automatic report_and_stop();
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (5) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        chk("id_rst", CIO_ID_DEFAULT, LINK_ID);
        chk("ext_rst", 1, LINK_EXT_CLK);
        bus(0, CIO_OFF_CTRL, 0);
        chk("ctrl_rst", CIO_CTRL_RST, rq);
        bus(0, 8'h20, 0);
        chk("unmapped", {CIO_RESP_SLVERR, 32'h0}, {rr, rq});
        bus(1, CIO_OFF_STATUS, 0);
        chk("status_ro", CIO_RESP_SLVERR, rr);
        foreach (ROWS[i]) begin
            bus(1, CIO_OFF_CTRL, ROWS[i].ctrl);
            bus(1, CIO_OFF_LINK, ROWS[i].link);
            {ROT_ID, ROT_RATE} <= {ROWS[i].rid, ROWS[i].rrate};
            repeat (6) @(posedge CORE_CLK);
            chk("id", ROWS[i].eid, LINK_ID);
            chk("ext", ROWS[i].eext, LINK_EXT_CLK);
            bus(0, CIO_OFF_LINK, 0);
            chk("rd_id", ROWS[i].eid, rq[21:16]);
        end
        bus(1, CIO_OFF_CTRL, 32'h0503);
        contact(CIO_IN_RUN, 1);
        chk("run", {32'd1, 5'h05}, {loads, PROG_FILE});
        contact(CIO_IN_PAUSE, 1);
        chk("pause", 3'b111, {PROG_PAUSED, FLOW_EN, SETPOINT_HOLD});
        contact(CIO_IN_PAUSE, 0);
        chk("no_edge", 1, PROG_PAUSED);
        contact(CIO_IN_PAUSE, 1);
        chk("resume", 2'b01, {PROG_PAUSED, STEP_EN});
        contact(CIO_IN_RUN, 0);
        chk("stop", 0, PROG_RUN);
        contact(CIO_IN_WAIT, 1);
        chk("wait", 1, WAIT_READY);
        contact(CIO_IN_SAFE, 1);
        chk("safe", {32'd2, CIO_SAFETY_FILE}, {loads, PROG_FILE});
        bus(1, CIO_OFF_RELAY, 32'ha);
        bus(1, CIO_OFF_RELAY, 32'h2000c);
        @(posedge CORE_CLK);
        chk("rly_on", 4'h5, RELAY_OUT);
        repeat (40) @(posedge CORE_CLK);
        bus(1, CIO_OFF_RELAY, 32'h6);
        @(posedge CORE_CLK);
        chk("rly_off", 4'h0, RELAY_OUT);
        bus(1, CIO_OFF_CTRL, 32'h0506);
        @(posedge CORE_CLK);
        chk("aux_man", 1, AUX_12V_EN);
        bus(1, CIO_OFF_CTRL, 32'h050a);
        AUX_STEP_ON <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        chk("aux_auto", 1, AUX_12V_EN);
        bus(1, CIO_OFF_LINK, 32'h01);
        t0 = ticks;
        cio_partner_inst.frame(8);
        repeat (10) @(posedge CORE_CLK);
        chk("ext_ticks", 8, ticks - t0);
        bus(1, CIO_OFF_LINK, 32'h501);
        t0 = ticks;
        repeat (100) @(posedge CORE_CLK);
        chk("int_ticks", 1, (ticks - t0) inside {[24:26]});
        report_and_stop();
    end
endmodule : cio_contact_io_tb_top
